// file: verilog/tmr_consts.svh
/*
 Register indices, field positions, reset values and fixed counts of the 16-bit timer.
 Assumes one 25 MHz clock and an AXI4-Lite slave where byte address = 4 * index.
*/
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

`define TMR_IDX_CTRL_A      8'h80
`define TMR_IDX_CTRL_B      8'h81
`define TMR_IDX_COUNT       8'h84
`define TMR_IDX_CAPTURE     8'h85
`define TMR_IDX_CMP_A       8'h86
`define TMR_IDX_CMP_B       8'h87
`define TMR_IDX_CMP_C       8'h88
`define TMR_IDX_FLAGS       8'h89

`define TMR_CTRL_A_RST      8'h00
`define TMR_CTRL_B_RST      8'h00
`define TMR_CTRL_B_WMASK    8'hDF
`define TMR_COM_A_LSB       6
`define TMR_COM_B_LSB       4
`define TMR_COM_C_LSB       2
`define TMR_WGM_LO_LSB      0
`define TMR_FILT_BIT        7
`define TMR_EDGE_BIT        6
`define TMR_WGM_HI_LSB      3
`define TMR_CS_LSB          0

`define TMR_FLAG_OVF        0
`define TMR_FLAG_CMP_LSB    1
`define TMR_FLAG_CAP        5

`define TMR_MAX             16'hFFFF
`define TMR_TOP8            16'h00FF
`define TMR_TOP9            16'h01FF
`define TMR_TOP10           16'h03FF
`define TMR_FILTER_SAMPLES  4
`define TMR_PRE_W           10

`define TMR_CS_STOP         3'h0
`define TMR_CS_DIV1         3'h1
`define TMR_CS_DIV8         3'h2
`define TMR_CS_DIV64        3'h3
`define TMR_CS_DIV256       3'h4
`define TMR_CS_DIV1024      3'h5
`define TMR_CS_EXT_FALL     3'h6
`define TMR_CS_EXT_RISE     3'h7

`define TMR_RESP_OKAY       2'h0
`define TMR_RESP_SLVERR     2'h2

`endif

// file: verilog/tmr_pkg.sv
/*
 Types shared by the timer files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tmr_pkg;
    typedef enum logic [2:0] {
        TMR_NORMAL,
        TMR_CTC,
        TMR_FAST,
        TMR_PC,
        TMR_PFC
    } tmr_kind_t;
endpackage

// file: verilog/tmr_prescaler.sv
/*
 Prescaler: turns the clock select field into a one-cycle timer tick enable.
 Assumes the external count pin is already synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_prescaler (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Control
    input  wire logic [2:0]  clock_source_sel,
    input  wire logic        ext_count_pin,
    // Tick
    output logic             timer_tick
);
    logic [`TMR_PRE_W-1:0] pre_q;
    logic                  ext_q;
    logic                  tick_d;

    // Free-running divider; shared taps keep every rate phase-locked to one counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_q <= '0;
            ext_q <= 1'b0;
        end else begin
            pre_q <= pre_q + 1'b1;
            ext_q <= ext_count_pin;
        end
    end

    always_comb begin
        case (clock_source_sel)
            `TMR_CS_DIV1:     tick_d = 1'b1;
            `TMR_CS_DIV8:     tick_d = &pre_q[2:0];
            `TMR_CS_DIV64:    tick_d = &pre_q[5:0];
            `TMR_CS_DIV256:   tick_d = &pre_q[7:0];
            `TMR_CS_DIV1024:  tick_d = &pre_q[9:0];
            `TMR_CS_EXT_FALL: tick_d = ext_q & ~ext_count_pin;
            `TMR_CS_EXT_RISE: tick_d = ~ext_q & ext_count_pin;
            default:          tick_d = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) timer_tick <= 1'b0;
        else     timer_tick <= tick_d;
    end
endmodule // tmr_prescaler

// file: verilog/tmr_capture_filter.sv
/*
 Capture input conditioning: optional majority-free noise filter and edge selection.
 Assumes the capture pin is synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_capture_filter #(
    parameter int SAMPLES = `TMR_FILTER_SAMPLES
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Pin and control
    input  wire logic capture_input_pin,
    input  wire logic capture_noise_filter_en,
    input  wire logic capture_edge_sel,
    // Event
    output logic      capture_evt
);
    logic [SAMPLES-1:0] samp_q;
    logic               filt_q;
    logic               prev_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            samp_q <= '0;
            filt_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            samp_q <= {samp_q[SAMPLES-2:0], capture_input_pin};
            prev_q <= filt_q;
            // Filter trades SAMPLES cycles of latency for glitch immunity
            if (!capture_noise_filter_en) filt_q <= capture_input_pin;
            else if (&samp_q)             filt_q <= 1'b1;
            else if (~|samp_q)            filt_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) capture_evt <= 1'b0;
        else     capture_evt <= capture_edge_sel ? (filt_q & ~prev_q) : (~filt_q & prev_q);
    end
endmodule // tmr_capture_filter

// file: verilog/tmr_timer16.sv
/*
 16-bit timer/counter with three compare channels, one capture channel and an AXI4-Lite register port.
 Assumes synchronous pins, one clock, and an outside port mux that uses the override and enable outputs.
*/
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_timer16 #(
    parameter int ADDR_W = 12,
    parameter int CH     = 3
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Pins
    input  wire logic              capture_input_pin,
    input  wire logic              ext_count_pin,
    input  wire logic [CH-1:0]     pin_direction_bit,
    output logic [CH-1:0]          compare_output_pin_q,
    output logic [CH-1:0]          compare_output_oe_q,
    output logic [CH-1:0]          port_override_q
);
    logic [7:0]      ctrl_a_q;
    logic [7:0]      ctrl_b_q;
    logic [15:0]     cnt_q;
    logic            dir_up_q;
    logic [15:0]     cap_q;
    logic [15:0]     cmp_buf_q [CH];
    logic [15:0]     cmp_act_q [CH];
    logic [CH-1:0]   oc_q;
    logic [5:0]      flags_q;
    logic            awready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]      bresp_q, rresp_q;
    logic [31:0]     rdata_q;

    logic            timer_tick;
    logic            capture_evt;
    logic [3:0]      waveform_mode;
    tmr_pkg::tmr_kind_t kind;
    logic [15:0]     top;
    logic            top_is_icr;
    logic            top_is_ocra;
    logic            at_top, at_bot, dual_bot, upd_evt, ovf_evt;
    logic [CH-1:0]   match;
    logic            wr_en, rd_en, aw_take, ar_take;
    logic [5:0]      flag_set, flag_clr;
    logic [31:0]     rd_mux;
    logic            rd_hit;
    logic [CH-1:0]   cmp_wr;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a[ADDR_W-1:10] == '0) && (a[9:2] == idx);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    tmr_prescaler u_prescaler (
        .ref_clk          (ref_clk),
        .rst              (rst),
        .clock_source_sel (ctrl_b_q[`TMR_CS_LSB +: 3]),
        .ext_count_pin    (ext_count_pin),
        .timer_tick       (timer_tick)
    );

    tmr_capture_filter #(.SAMPLES(`TMR_FILTER_SAMPLES)) u_capture (
        .ref_clk                 (ref_clk),
        .rst                     (rst),
        .capture_input_pin       (capture_input_pin),
        .capture_noise_filter_en (ctrl_b_q[`TMR_FILT_BIT]),
        .capture_edge_sel        (ctrl_b_q[`TMR_EDGE_BIT]),
        .capture_evt             (capture_evt)
    );

    // Mode decode
    assign waveform_mode = {ctrl_b_q[`TMR_WGM_HI_LSB +: 2], ctrl_a_q[`TMR_WGM_LO_LSB +: 2]};

    always_comb begin
        kind        = tmr_pkg::TMR_NORMAL;
        top         = `TMR_MAX;
        top_is_icr  = 1'b0;
        top_is_ocra = 1'b0;
        case (waveform_mode)
            4'h0: kind = tmr_pkg::TMR_NORMAL;
            4'h1: begin kind = tmr_pkg::TMR_PC;   top = `TMR_TOP8;  end
            4'h2: begin kind = tmr_pkg::TMR_PC;   top = `TMR_TOP9;  end
            4'h3: begin kind = tmr_pkg::TMR_PC;   top = `TMR_TOP10; end
            4'h4: begin kind = tmr_pkg::TMR_CTC;  top = cmp_act_q[0]; top_is_ocra = 1'b1; end
            4'h5: begin kind = tmr_pkg::TMR_FAST; top = `TMR_TOP8;  end
            4'h6: begin kind = tmr_pkg::TMR_FAST; top = `TMR_TOP9;  end
            4'h7: begin kind = tmr_pkg::TMR_FAST; top = `TMR_TOP10; end
            4'h8: begin kind = tmr_pkg::TMR_PFC;  top = cap_q; top_is_icr = 1'b1; end
            4'h9: begin kind = tmr_pkg::TMR_PFC;  top = cmp_act_q[0]; top_is_ocra = 1'b1; end
            4'hA: begin kind = tmr_pkg::TMR_PC;   top = cap_q; top_is_icr = 1'b1; end
            4'hB: begin kind = tmr_pkg::TMR_PC;   top = cmp_act_q[0]; top_is_ocra = 1'b1; end
            4'hC: begin kind = tmr_pkg::TMR_CTC;  top = cmp_act_q[0]; top_is_ocra = 1'b1; end
            4'hE: begin kind = tmr_pkg::TMR_FAST; top = cap_q; top_is_icr = 1'b1; end
            4'hF: begin kind = tmr_pkg::TMR_FAST; top = cmp_act_q[0]; top_is_ocra = 1'b1; end
            // Reserved code runs as plain normal mode rather than locking up
            default: kind = tmr_pkg::TMR_NORMAL;
        endcase
    end

    // Counter events; upd_evt and ovf_evt are qualified by the tick, the at_top, at_bot and dual_bot compares are not
    assign at_top   = (cnt_q == top);
    assign at_bot   = (cnt_q == 16'h0000);
    assign dual_bot = at_bot && !dir_up_q;

    always_comb begin
        upd_evt = 1'b0;
        ovf_evt = 1'b0;
        case (kind)
            tmr_pkg::TMR_NORMAL,
            tmr_pkg::TMR_CTC:  ovf_evt = timer_tick && (cnt_q == `TMR_MAX);
            tmr_pkg::TMR_FAST: begin
                upd_evt = timer_tick && at_top;
                ovf_evt = timer_tick && at_top;
            end
            tmr_pkg::TMR_PC: begin
                upd_evt = timer_tick && at_top && dir_up_q;
                ovf_evt = timer_tick && dual_bot;
            end
            tmr_pkg::TMR_PFC: begin
                upd_evt = timer_tick && dual_bot;
                ovf_evt = timer_tick && dual_bot;
            end
            default: ;
        endcase
    end

    // Counter and count direction; a bus write to the counter wins over the tick
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q    <= 16'h0000;
            dir_up_q <= 1'b1;
        end else if (wr_en && hit(s_axi_awaddr, `TMR_IDX_COUNT)) begin
            cnt_q <= merge16(cnt_q, s_axi_wdata, s_axi_wstrb);
        end else if (timer_tick) begin
            if (kind == tmr_pkg::TMR_PC || kind == tmr_pkg::TMR_PFC) begin
                if (dir_up_q && at_top) begin
                    dir_up_q <= 1'b0;
                    cnt_q    <= cnt_q - 16'h0001;
                end else if (!dir_up_q && at_bot) begin
                    dir_up_q <= 1'b1;
                    cnt_q    <= cnt_q + 16'h0001;
                end else begin
                    cnt_q <= dir_up_q ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
                end
            end else begin
                dir_up_q <= 1'b1;
                cnt_q    <= at_top ? 16'h0000 : cnt_q + 16'h0001;
            end
        end
    end

    // Capture register; software may also write it to set TOP
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cap_q <= 16'h0000;
        end else if (capture_evt && !top_is_icr) begin
            cap_q <= cnt_q;
        end else if (wr_en && hit(s_axi_awaddr, `TMR_IDX_CAPTURE)) begin
            cap_q <= merge16(cap_q, s_axi_wdata, s_axi_wstrb);
        end
    end

    // Compare channels
    genvar gi;
    generate
        for (gi = 0; gi < CH; gi++) begin : g_ch
            logic [1:0] com;
            assign com        = ctrl_a_q[`TMR_COM_A_LSB - 2*gi +: 2];
            assign cmp_wr[gi] = wr_en && hit(s_axi_awaddr, 8'(`TMR_IDX_CMP_A + gi));
            assign match[gi]  = timer_tick && (cnt_q == cmp_act_q[gi]);

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    cmp_buf_q[gi] <= 16'h0000;
                end else if (cmp_wr[gi]) begin
                    cmp_buf_q[gi] <= merge16(cmp_buf_q[gi], s_axi_wdata, s_axi_wstrb);
                end
            end

            // Non-PWM modes use the written value at once; PWM modes wait for the update point
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    cmp_act_q[gi] <= 16'h0000;
                end else if (kind == tmr_pkg::TMR_NORMAL || kind == tmr_pkg::TMR_CTC) begin
                    cmp_act_q[gi] <= cmp_buf_q[gi];
                end else if (upd_evt) begin
                    cmp_act_q[gi] <= cmp_buf_q[gi];
                end
            end

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    oc_q[gi] <= 1'b0;
                end else if (timer_tick) begin
                    case (kind)
                        tmr_pkg::TMR_NORMAL,
                        tmr_pkg::TMR_CTC: begin
                            if (match[gi]) begin
                                case (com)
                                    2'd1:    oc_q[gi] <= ~oc_q[gi];
                                    2'd2:    oc_q[gi] <= 1'b0;
                                    2'd3:    oc_q[gi] <= 1'b1;
                                    default: oc_q[gi] <= oc_q[gi];
                                endcase
                            end
                        end
                        tmr_pkg::TMR_FAST: begin
                            if (com[1] && match[gi])  oc_q[gi] <= com[0];
                            else if (com[1] && at_top) oc_q[gi] <= ~com[0];
                            else if (com == 2'd1 && gi == 0 && top_is_ocra && match[gi]) oc_q[gi] <= ~oc_q[gi];
                        end
                        tmr_pkg::TMR_PC,
                        tmr_pkg::TMR_PFC: begin
                            if (com[1]) begin
                                if (cmp_act_q[gi] == 16'h0000)  oc_q[gi] <= com[0];
                                else if (cmp_act_q[gi] == top)  oc_q[gi] <= ~com[0];
                                else if (match[gi])             oc_q[gi] <= dir_up_q ? com[0] : ~com[0];
                            end else if (com == 2'd1 && gi == 0 && top_is_ocra && match[gi]) begin
                                oc_q[gi] <= ~oc_q[gi];
                            end
                        end
                        default: oc_q[gi] <= oc_q[gi];
                    endcase
                end
            end

            // Pin drive; the port mux outside uses override and enable
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    compare_output_pin_q[gi] <= 1'b0;
                    compare_output_oe_q[gi]  <= 1'b0;
                    port_override_q[gi]      <= 1'b0;
                end else begin
                    port_override_q[gi]      <= (com != 2'd0);
                    compare_output_oe_q[gi]  <= (com != 2'd0) && pin_direction_bit[gi];
                    compare_output_pin_q[gi] <= (com != 2'd0) && pin_direction_bit[gi] && oc_q[gi];
                end
            end
        end
    endgenerate

    // Flags: hardware set wins over a write-one clear in the same cycle
    always_comb begin
        flag_set = '0;
        flag_set[`TMR_FLAG_OVF] = ovf_evt;
        flag_set[`TMR_FLAG_CMP_LSB +: CH] = match;
        flag_set[`TMR_FLAG_CAP] = (capture_evt && !top_is_icr) || (top_is_icr && timer_tick && at_top);
        flag_clr = (wr_en && hit(s_axi_awaddr, `TMR_IDX_FLAGS) && s_axi_wstrb[0]) ? s_axi_wdata[5:0] : 6'h00;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) flags_q <= 6'h00;
        else     flags_q <= (flags_q & ~flag_clr) | flag_set;
    end

    // Control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_a_q <= `TMR_CTRL_A_RST;
            ctrl_b_q <= `TMR_CTRL_B_RST;
        end else if (wr_en && s_axi_wstrb[0]) begin
            if (hit(s_axi_awaddr, `TMR_IDX_CTRL_A)) ctrl_a_q <= s_axi_wdata[7:0];
            if (hit(s_axi_awaddr, `TMR_IDX_CTRL_B)) ctrl_b_q <= s_axi_wdata[7:0] & `TMR_CTRL_B_WMASK;
        end
    end

    // AXI4-Lite write channel: address and data are taken together
    assign aw_take = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
    assign wr_en   = awready_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            awready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `TMR_RESP_OKAY;
        end else begin
            awready_q <= aw_take;
            if (wr_en) begin
                bvalid_q <= 1'b1;
                bresp_q  <= (s_axi_awaddr[ADDR_W-1:10] == '0 &&
                             (s_axi_awaddr[9:2] inside {`TMR_IDX_CTRL_A, `TMR_IDX_CTRL_B}
                              || (s_axi_awaddr[9:2] >= `TMR_IDX_COUNT && s_axi_awaddr[9:2] <= `TMR_IDX_FLAGS)))
                            ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    assign ar_take = s_axi_arvalid && !arready_q && !rvalid_q;
    assign rd_en   = arready_q;

    always_comb begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        if (hit(s_axi_araddr, `TMR_IDX_CTRL_A))       rd_mux[7:0]  = ctrl_a_q;
        else if (hit(s_axi_araddr, `TMR_IDX_CTRL_B))  rd_mux[7:0]  = ctrl_b_q;
        else if (hit(s_axi_araddr, `TMR_IDX_COUNT))   rd_mux[15:0] = cnt_q;
        else if (hit(s_axi_araddr, `TMR_IDX_CAPTURE)) rd_mux[15:0] = cap_q;
        else if (hit(s_axi_araddr, `TMR_IDX_CMP_A))   rd_mux[15:0] = cmp_buf_q[0];
        else if (hit(s_axi_araddr, `TMR_IDX_CMP_B))   rd_mux[15:0] = cmp_buf_q[1];
        else if (hit(s_axi_araddr, `TMR_IDX_CMP_C))   rd_mux[15:0] = cmp_buf_q[2];
        else if (hit(s_axi_araddr, `TMR_IDX_FLAGS))   rd_mux[5:0]  = flags_q;
        else                                          rd_hit       = 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `TMR_RESP_OKAY;
        end else begin
            arready_q <= ar_take;
            if (rd_en) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= rd_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = awready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
endmodule // tmr_timer16

// file: test/tmr_timer16_assertions.sv
/* Checker: bus handshakes and pin gating of the timer top.
   Assumes it is bound into every tmr_timer16. */
`timescale 1ns/1ps
module tmr_timer16_assertions #(parameter int CH = 3) (
    // Clock and reset
    input wire logic          ref_clk,
    input wire logic          rst,
    // Bus handshakes
    input wire logic          s_axi_awready,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    input wire logic          s_axi_rvalid,
    input wire logic          s_axi_rready,
    // Pins
    input wire logic [CH-1:0] pin_direction_bit,
    input wire logic [CH-1:0] compare_output_pin_q,
    input wire logic [CH-1:0] compare_output_oe_q,
    input wire logic [CH-1:0] port_override_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    w_lat_a: assert property (s_axi_awready |=> s_axi_bvalid) else $error("no bvalid");
    w_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid drop");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid drop");
    oe_dir_a: assert property ((compare_output_oe_q & ~$past(pin_direction_bit)) == '0)
        else $error("driver without direction");
    pin_gate_a: assert property ((compare_output_pin_q & ~compare_output_oe_q) == '0)
        else $error("pin without driver");
    oe_ovr_a: assert property ((compare_output_oe_q & ~port_override_q) == '0)
        else $error("driver without override");
    reset_idle_a: assert property ($fell(rst) |-> (port_override_q == '0) [*2])
        else $error("override after reset");
    ovr_wr_a: assert property ($changed(port_override_q) |-> $past(s_axi_awready) || $past(s_axi_awready, 2))
        else $error("override without write");
endmodule // tmr_timer16_assertions
bind tmr_timer16 tmr_timer16_assertions #(.CH(CH)) chk (.*);

// file: test/tmr_pin_model.sv
/* Pin partner: capture source, direction bits, pulled-up pads.
   Assumes the bench steers it at the rising edge. */
`timescale 1ns/1ps
module tmr_pin_model (
    // Bench side
    input wire logic       cap_level,
    input wire logic [2:0] dir_sel,
    input wire logic [2:0] compare_output_pin_q,
    input wire logic [2:0] compare_output_oe_q,
    // Device pins
    output logic           capture_input_pin,
    output logic           ext_count_pin,
    output logic [2:0]     pin_direction_bit,
    output logic [2:0]     pad_level
);
    assign capture_input_pin = cap_level;
    assign ext_count_pin = ~cap_level;
    assign pin_direction_bit = dir_sel;
    // Released pads rise through the pull-up, never keep the last level
    assign pad_level = compare_output_pin_q | ~compare_output_oe_q;
endmodule // tmr_pin_model

// file: test/tb_tmr_timer16.sv
/* Bench: timer top through AXI4-Lite and the pin model.
   Assumes one 25 MHz clock and no other master. */
`timescale 1ns/1ps
module tb_tmr_timer16;
    logic ref_clk = 0, rst = 1, cap_level = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, capture_input_pin, ext_count_pin;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, dir_sel = 3'h5, pad_level, pin_direction_bit;
    logic [2:0] compare_output_pin_q, compare_output_oe_q, port_override_q;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs_q;
    int errors = 0, compares = 0;
    int gap_q;
    tmr_timer16 uut (.*);
    tmr_pin_model pins (.*);
    always #20 ref_clk = ~ref_clk;
    task stop_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task wt(input logic w, r);
        int n;
        n = 0;
        do @(negedge ref_clk);
        while ((r ? (w ? s_axi_bvalid : s_axi_rvalid) : (w ? s_axi_awready : s_axi_arready)) !== 1'b1 && ++n < 99);
        if (n == 99) begin
            errors++;
            stop_test;
        end
    endtask
    // Ready lags the response by a cycle so the hold checks see a wait
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {w, w, !w, a, a, d};
        wt(w, 1'b0);
        @(posedge ref_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
        wt(w, 1'b1);
        {rd_q, rs_q} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
        @(posedge ref_clk);
        {s_axi_bready, s_axi_rready} <= {w, !w};
        @(posedge ref_clk);
        {s_axi_bready, s_axi_rready} <= 2'h0;
    endtask
    // Cycles between two toggles of channel A's pad; the first toggle only aligns the count
    task gap(output int c);
        logic p;
        for (int j = 0; j < 2; j++) begin
            p = pad_level[0];
            c = 0;
            do begin
                @(negedge ref_clk);
                c++;
            end while (pad_level[0] === p && c < 999);
            if (c >= 999) begin
                errors++;
                stop_test;
            end
        end
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        bus(0, 12'h200, 0);
        chk("ctrl_a", rd_q, 32'h0);
        bus(0, 12'h204, 0);
        chk("ctrl_b", rd_q, 32'h0);
        bus(1, 12'h204, 32'hF8);
        bus(0, 12'h204, 0);
        chk("ctrl_b", rd_q, 32'hD8);
        bus(0, 12'h3FC, 0);
        chk("resp", rs_q, 32'h2);
        for (int i = 0; i < 3; i++) bus(1, 12'(12'h218 + 4 * i), 32'h40);
        bus(1, 12'h204, 32'h01);
        for (int m = 3; m > 0; m--) begin
            bus(1, 12'h200, 32'h54 * m);
            bus(1, 12'h210, 32'h30);
            repeat (40) @(posedge ref_clk);
            chk("pad", pad_level, m == 2 ? 3'h2 : 3'h7);
        end
        for (int k = 0; k < 4; k++) begin
            bus(1, 12'h204, k == 0 ? 32'hC1 : k == 1 ? 32'h41 : 32'h01);
            bus(1, 12'h224, 32'h20);
            cap_level <= ~cap_level;
            repeat (10) @(posedge ref_clk);
            bus(0, 12'h224, 0);
            chk("cap", rd_q[5], k == 0 || k == 3);
        end
        // Mode 9 is set while stopped at zero so the counter never starts above TOP
        bus(1, 12'h220, 32'h0);
        bus(1, 12'h204, 32'h10);
        bus(1, 12'h210, 32'h0);
        bus(1, 12'h200, 32'h49);
        bus(1, 12'h204, 32'h11);
        gap(gap_q);
        chk("period", gap_q, 32'h80);
        chk("pwm_low", pad_level[2], 32'h0);
        bus(1, 12'h224, 32'h3F);
        bus(1, 12'h218, 32'h20);
        gap(gap_q);
        gap(gap_q);
        chk("new_period", gap_q, 32'h40);
        bus(0, 12'h224, 0);
        chk("ovf", rd_q[1:0], 32'h3);
        bus(1, 12'h200, 32'h4D);
        repeat (4) @(posedge ref_clk);
        chk("pwm_high", pad_level[2], 32'h1);
        stop_test;
    end
endmodule // tb_tmr_timer16
